// ### rtl/cipher_key_and_config_regs.sv
// Register bank holding the cipher key words, last-block byte count and configuration word
//
// Summary of operation
// R1: Eight 32-bit key words; word n holds key bytes 4n to 4n+3.
// R2: Four-bit count of valid bytes in the last counter-CBC-MAC block.
// R3: Revision field in configuration bits 31:28 is read-only.
// R4: Writing one to bit 26 pulses a hash restart; bit reads zero.
// R5: Keyed hash enable, bit 21, clears itself when the keyed hash finishes.
// R6: Software sets the keyed hash enable again before every new calculation.
// R7: Bit 20 enables cipher MAC mode.
// R8: Bit 19 enables counter-with-CBC-MAC mode, standard and starred.
// R9: Bit 18 enables cipher block chaining mode.
// R10: Bit 17 enables counter mode.
// R11: Bit 16 enables electronic codebook mode.
// R12: Software enables at most one cipher mode at a time.
// R13: Key words and configuration survive the hibernation reset.
// R14: A read-write bit of the configuration word enables the hash engine.
//
// The register addresses and the address-and-strobe port were chosen for this implementation.

`include "cipher_regs_defines.svh"

module cipher_key_and_config_regs
	import cipher_regs_pkg::*;
#(
	// Arbitrary revision value reported in the configuration word
	parameter logic [3:0] REVISION = `REVISION_DEFAULT
)
(
	// Clock and resets
	input  wire logic         CLOCK,
	input  wire logic         RST_N,
	input  wire logic         HIB_RST_N,
	// Register port
	input  wire logic [7:0]   ADDR,
	input  wire logic [31:0]  WR_DATA,
	input  wire logic         WR_STB,
	input  wire logic         RD_STB,
	output logic      [31:0]  RD_DATA,
	// Hash engine
	input  wire logic         KEYED_HASH_DONE,
	output logic              HASH_RESTART,
	output logic              HASH_ENABLE,
	output logic              KEYED_HASH_ENABLE,
	// Cipher engine
	output logic      [255:0] CIPHER_KEY,
	output logic      [3:0]   LAST_BLOCK_VALID_BYTES,
	output logic              CIPHER_MAC_MODE_ENABLE,
	output logic              COUNTER_CBC_MAC_ENABLE,
	output logic              BLOCK_CHAINING_ENABLE,
	output logic              COUNTER_MODE_ENABLE,
	output logic              CODEBOOK_MODE_ENABLE
);

	// ==========================================================
	// Declarations
	regs_t       cur_ff;
	regs_t       nxt_regs;
	logic [7:0]  key_hit;
	logic [31:0] key_rd;
	logic [31:0] cfg_word;
	logic [6:0]  cfg_view;
	logic        vb_hit;
	logic        cfg_hit;

	// ==========================================================
	// Address decode
	// Address decode, one comparator per key word
	generate
		for (genvar i = 0; i < 8; i++)
		begin : g_key
			assign key_hit[i] = (ADDR == 8'(`KEY_WORD0_OFS + i * `KEY_WORD_STRIDE));
		end
	endgenerate

	assign vb_hit  = (ADDR == `VALID_BYTES_OFS);
	assign cfg_hit = (ADDR == `CONFIG_OFS);

	// Read view of the key words
	always_comb
	begin
		key_rd = 32'h0000_0000;
		for (int k = 0; k < 8; k++)
		begin
			if (key_hit[k])
			begin
				key_rd = cur_ff.key[k]; // [R1]
			end
		end
	end

	// Read view of the configuration word; restart bit always reads zero
	always_comb
	begin
		cfg_word = 32'h0000_0000;
		cfg_word[`REV_MSB:`REV_LSB] = REVISION; // [R3]
		cfg_word[`HASH_RESTART_BIT] = 1'b0; // [R4]
		cfg_word[`HASH_ENABLE_BIT] = cur_ff.hash_en;
		cfg_word[`KEYED_HASH_BIT] = cur_ff.keyed_hash_en;
		cfg_word[`MAC_MODE_BIT:`ECB_MODE_BIT] = cur_ff.mode_en;
	end

	// ==========================================================
	// Next state
	always_comb
	begin
		nxt_regs = cur_ff;
		nxt_regs.restart = 1'b0;
		nxt_regs.rdata = 32'h0000_0000;
		// Key words keep their value unless written
		for (int k = 0; k < 8; k++)
		begin
			if (WR_STB && key_hit[k])
			begin
				nxt_regs.key[k] = WR_DATA; // [R1]
			end
		end
		if (WR_STB && vb_hit)
		begin
			nxt_regs.valid_bytes = WR_DATA[`VALID_BYTES_MSB:0]; // [R2]
		end
		// Engine completion clears the keyed hash enable
		if (KEYED_HASH_DONE)
		begin
			nxt_regs.keyed_hash_en = 1'b0; // [R5]
		end
		// A write wins over completion in the same cycle; revision bits are ignored
		if (WR_STB && cfg_hit)
		begin
			nxt_regs.restart = WR_DATA[`HASH_RESTART_BIT]; // [R4]
			nxt_regs.hash_en = WR_DATA[`HASH_ENABLE_BIT]; // [R14]
			nxt_regs.keyed_hash_en = WR_DATA[`KEYED_HASH_BIT]; // [R5] [R6]
			nxt_regs.mode_en = WR_DATA[`MAC_MODE_BIT:`ECB_MODE_BIT]; // [R7] [R8] [R9] [R10] [R11]
		end
		// Read data stands only in the cycle after the strobe
		if (RD_STB)
		begin
			if (vb_hit)
			begin
				nxt_regs.rdata = {28'h0000000, cur_ff.valid_bytes}; // [R2]
			end
			else if (cfg_hit)
			begin
				nxt_regs.rdata = cfg_word;
			end
			else
			begin
				nxt_regs.rdata = key_rd;
			end
		end
		// Hibernation clears only the byte count, the restart pulse and the read data
		if (!HIB_RST_N)
		begin
			nxt_regs.valid_bytes = `VALID_BYTES_RESET; // [R13]
			nxt_regs.restart = 1'b0;
			nxt_regs.rdata = 32'h0000_0000;
		end
	end

	// ==========================================================
	// State register
	// Synchronous reset of the whole bank; hibernation is handled in the next-state logic
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
		begin
			cur_ff.key <= {8{`KEY_WORD_RESET}};
			cur_ff.valid_bytes <= `VALID_BYTES_RESET;
			cur_ff.hash_en <= 1'b0;
			cur_ff.keyed_hash_en <= 1'b0;
			cur_ff.mode_en <= `MODE_RESET;
			cur_ff.restart <= 1'b0;
			cur_ff.rdata <= 32'h0000_0000;
		end
		else
		begin
			cur_ff <= nxt_regs;
		end
	end

	// ==========================================================
	// Outputs
	assign RD_DATA = cur_ff.rdata;
	assign HASH_RESTART = cur_ff.restart;
	assign HASH_ENABLE = cur_ff.hash_en;
	assign KEYED_HASH_ENABLE = cur_ff.keyed_hash_en;
	assign CIPHER_KEY = cur_ff.key;
	assign LAST_BLOCK_VALID_BYTES = cur_ff.valid_bytes;
	assign CIPHER_MAC_MODE_ENABLE = cur_ff.mode_en[4];
	assign COUNTER_CBC_MAC_ENABLE = cur_ff.mode_en[3];
	assign BLOCK_CHAINING_ENABLE = cur_ff.mode_en[2];
	assign COUNTER_MODE_ENABLE = cur_ff.mode_en[1];
	assign CODEBOOK_MODE_ENABLE = cur_ff.mode_en[0];

	// ==========================================================
	// Checks
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RST_N);

	// Write and read of a key word
	sequence s_key3_write;
		WR_STB && ADDR == 8'h0c;
	endsequence
	property p_key_word;
		s_key3_write ##1 (RD_STB && ADDR == 8'h0c && !WR_STB && HIB_RST_N)
			|=> RD_DATA == $past(WR_DATA, 2) && CIPHER_KEY[127:96] == $past(WR_DATA, 2);
	endproperty
	a_key_word: assert property (p_key_word) else $error("Key word 3 lost its write"); // [R1]

	property p_valid_bytes;
		(WR_STB && vb_hit && HIB_RST_N) |=> LAST_BLOCK_VALID_BYTES == $past(WR_DATA[3:0]);
	endproperty
	a_valid_bytes: assert property (p_valid_bytes) else $error("Valid byte count not stored"); // [R2]

	property p_revision;
		(RD_STB && cfg_hit && HIB_RST_N) |=> RD_DATA[31:28] == REVISION && !RD_DATA[26];
	endproperty
	a_revision: assert property (p_revision) else $error("Revision or restart bit read wrong"); // [R3]

	// Restart is a single pulse after the write
	sequence s_restart_write;
		WR_STB && cfg_hit && WR_DATA[26] && HIB_RST_N;
	endsequence
	sequence s_restart_pulse;
		HASH_RESTART ##1 !HASH_RESTART;
	endsequence
	property p_restart;
		s_restart_write ##1 !(WR_STB && cfg_hit && WR_DATA[26]) |-> s_restart_pulse;
	endproperty
	a_restart: assert property (p_restart) else $error("Hash restart not a one-cycle pulse"); // [R4]

	property p_restart_cause;
		HASH_RESTART |-> $past(WR_STB && cfg_hit && WR_DATA[26]);
	endproperty
	a_restart_cause: assert property (p_restart_cause) else $error("Spurious hash restart"); // [R4]

	property p_keyed_clear;
		(KEYED_HASH_DONE && !(WR_STB && cfg_hit)) |=> !KEYED_HASH_ENABLE;
	endproperty
	a_keyed_clear: assert property (p_keyed_clear) else $error("Keyed hash enable not cleared"); // [R5]

	property p_keyed_set;
		(WR_STB && cfg_hit && WR_DATA[21]) |=> KEYED_HASH_ENABLE;
	endproperty
	a_keyed_set: assert property (p_keyed_set) else $error("Keyed hash enable not set"); // [R5]

	property p_modes;
		(WR_STB && cfg_hit) |=> {CIPHER_MAC_MODE_ENABLE, COUNTER_CBC_MAC_ENABLE, BLOCK_CHAINING_ENABLE,
			COUNTER_MODE_ENABLE, CODEBOOK_MODE_ENABLE} == $past(WR_DATA[20:16]);
	endproperty
	a_modes: assert property (p_modes) else $error("Mode enables not stored"); // [R7] [R8] [R9] [R10] [R11]

	property p_hash_enable;
		(WR_STB && cfg_hit) |=> HASH_ENABLE == $past(WR_DATA[22]);
	endproperty
	a_hash_enable: assert property (p_hash_enable) else $error("Hash enable not stored"); // [R14]

	property p_hibernate;
		(!HIB_RST_N && !WR_STB && !KEYED_HASH_DONE) |=> $stable(CIPHER_KEY) && $stable(cfg_view)
			&& LAST_BLOCK_VALID_BYTES == 4'h0;
	endproperty
	a_hibernate: assert property (p_hibernate) else $error("Hibernation reset disturbed keys"); // [R13]

	// ==========================================================
	// Checks on holding and read-back
	// Hash and mode enables gathered in the order of their configuration bits 22 to 16
	assign cfg_view = {HASH_ENABLE, KEYED_HASH_ENABLE, CIPHER_MAC_MODE_ENABLE, COUNTER_CBC_MAC_ENABLE,
		BLOCK_CHAINING_ENABLE, COUNTER_MODE_ENABLE, CODEBOOK_MODE_ENABLE};

	// Read data stands for one cycle only, then returns to zero
	property p_read_idle;
		!RD_STB |=> RD_DATA == 32'h0000_0000;
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("Read data did not return to zero"); // [R1]

	// Key words change only when written
	property p_key_hold;
		!WR_STB |=> $stable(CIPHER_KEY);
	endproperty
	a_key_hold: assert property (p_key_hold) else $error("Key changed without a write"); // [R1] [R13]

	// Byte count reads back in the low nibble with the upper bits zero
	property p_valid_read;
		(RD_STB && vb_hit && HIB_RST_N) |=> RD_DATA == {28'h0000000, $past(LAST_BLOCK_VALID_BYTES)};
	endproperty
	a_valid_read: assert property (p_valid_read) else $error("Byte count read wrong"); // [R2]

	// Enables read back at their own bit positions
	property p_cfg_read;
		(RD_STB && cfg_hit && HIB_RST_N) |=> RD_DATA[22:16] == $past(cfg_view);
	endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("Enables read wrong"); // [R5] [R7] [R8] [R9] [R10] [R11] [R14]

	// Mode enables and the hash enable change only through a configuration write
	property p_cfg_hold;
		!(WR_STB && cfg_hit) |=> $stable({cfg_view[6], cfg_view[4:0]});
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("Enable changed without a write"); // [R7] [R8] [R9] [R10] [R11] [R14]

	// Keyed hash enable moves only on a write or on completion
	property p_keyed_hold;
		(!(WR_STB && cfg_hit) && !KEYED_HASH_DONE) |=> $stable(KEYED_HASH_ENABLE);
	endproperty
	a_keyed_hold: assert property (p_keyed_hold) else $error("Keyed hash enable changed alone"); // [R5]

endmodule

// ### rtl/cipher_regs_defines.svh
// Offsets, field positions and reset values of the cipher key and configuration registers
`ifndef CIPHER_REGS_DEFINES_SVH
`define CIPHER_REGS_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define KEY_WORD0_OFS      8'h00
`define KEY_WORD_STRIDE    8'h04
`define VALID_BYTES_OFS    8'h20
`define CONFIG_OFS         8'h24

// ==========================================================
// Field positions in the configuration word and in the byte count register
`define REV_MSB            31
`define REV_LSB            28
`define HASH_RESTART_BIT   26
`define HASH_ENABLE_BIT    22
`define KEYED_HASH_BIT     21
`define MAC_MODE_BIT       20
`define CCM_MODE_BIT       19
`define CBC_MODE_BIT       18
`define CTR_MODE_BIT       17
`define ECB_MODE_BIT       16
`define VALID_BYTES_MSB    3

// ==========================================================
// Reset values
`define KEY_WORD_RESET     32'h0000_0000
`define VALID_BYTES_RESET  4'h0
`define MODE_RESET         5'h00
`define REVISION_DEFAULT   4'h5

`endif

// ### rtl/cipher_regs_pkg.sv
// Types shared by the cipher key and configuration register bank
package cipher_regs_pkg;

	// ==========================================================
	// Whole state of the register bank
	typedef struct packed {
		logic [7:0][31:0] key;
		logic [3:0]       valid_bytes;
		logic             hash_en;
		logic             keyed_hash_en;
		logic [4:0]       mode_en;
		logic             restart;
		logic [31:0]      rdata;
	} regs_t;

endpackage

// ### verification/cipher_key_and_config_regs_tb.sv
// Self-checking testbench for the cipher key and configuration register bank
`include "cipher_regs_defines.svh"

module cipher_key_and_config_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Signals
	localparam logic [3:0] REV = 4'h9; // Arbitrary revision value
	logic         clock = 1'b0;
	logic         rst_n = 1'b0;
	logic         hib_rst_n = 1'b1;
	logic [7:0]   addr = 8'h00;
	logic [31:0]  wr_data = 32'h0;
	logic         wr_stb = 1'b0;
	logic         rd_stb = 1'b0;
	logic         done = 1'b0;
	logic [31:0]  rd_data;
	logic [31:0]  rv;
	logic [255:0] key;
	logic [255:0] key_exp;
	logic [3:0]   valid;
	logic         restart, hash_en, keyed_en, mac_en, ccm_en, cbc_en, ctr_en, ecb_en;
	logic [4:0]   modes;
	int           err_count = 0;
	int           n_checks = 0;

	// Mode enables gathered, cipher MAC mode on top
	assign modes = {mac_en, ccm_en, cbc_en, ctr_en, ecb_en};

	// Clock
	always #10 clock = ~clock;

	cipher_key_and_config_regs #(.REVISION(REV)) uut (
		.CLOCK(clock), .RST_N(rst_n), .HIB_RST_N(hib_rst_n),
		.ADDR(addr), .WR_DATA(wr_data), .WR_STB(wr_stb), .RD_STB(rd_stb), .RD_DATA(rd_data),
		.KEYED_HASH_DONE(done), .HASH_RESTART(restart), .HASH_ENABLE(hash_en),
		.KEYED_HASH_ENABLE(keyed_en), .CIPHER_KEY(key), .LAST_BLOCK_VALID_BYTES(valid),
		.CIPHER_MAC_MODE_ENABLE(mac_en), .COUNTER_CBC_MAC_ENABLE(ccm_en),
		.BLOCK_CHAINING_ENABLE(cbc_en), .COUNTER_MODE_ENABLE(ctr_en), .CODEBOOK_MODE_ENABLE(ecb_en)
	);

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [255:0] seen, input logic [255:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One-cycle write; outputs are settled when it returns
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wr_data <= d;
		wr_stb <= 1'b1;
		@(posedge clock);
		wr_stb <= 1'b0;
		#1;
	endtask

	// One-cycle read; data sampled in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clock);
		rd_stb <= 1'b0;
		#1;
		d = rd_data;
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		check({restart, hash_en, keyed_en, modes, valid}, 0);
		check(key, 0);
		rd(`CONFIG_OFS, rv);
		check(rv, {REV, 28'h0});
		$display("reset test done");
	endtask

	// All eight key words written, then the whole key and each word read back
	task automatic t_keys();
		for (int i = 0; i < 8; i++)
		begin
			key_exp[32*i +: 32] = 32'h0f1e_2d3c + 32'(i) * 32'h1101_0110;
			wr(`KEY_WORD0_OFS + 8'(i * 4), key_exp[32*i +: 32]);
		end
		check(key, key_exp);
		for (int i = 0; i < 8; i++)
		begin
			rd(`KEY_WORD0_OFS + 8'(i * 4), rv);
			check(rv, key_exp[32*i +: 32]);
		end
		// Write of key word 3 followed at once by its read
		@(posedge clock);
		addr <= 8'h0c;
		wr_data <= 32'h5a5a_a5a5;
		wr_stb <= 1'b1;
		@(posedge clock);
		wr_stb <= 1'b0;
		rd_stb <= 1'b1;
		@(posedge clock);
		rd_stb <= 1'b0;
		#1;
		key_exp[96 +: 32] = 32'h5a5a_a5a5;
		check(rd_data, 32'h5a5a_a5a5);
		check(key, key_exp);
		$display("key test done");
	endtask

	// Restart pulse, read-only revision, hash enable, then each mode alone
	task automatic t_config();
		wr(`CONFIG_OFS, 32'hffe0_ffff);
		check(restart, 1'b1);
		check(hash_en, 1'b1);
		@(posedge clock);
		#1;
		check(restart, 1'b0);
		rd(`CONFIG_OFS, rv);
		check(rv, {REV, 28'h060_0000});
		for (int i = 0; i < 5; i++)
		begin
			wr(`CONFIG_OFS, 32'h1 << (16 + i));
			check(modes, 5'h1 << i);
			rd(`CONFIG_OFS, rv);
			check(rv, {REV, 28'h0} | (32'h1 << (16 + i)));
		end
		$display("config test done");
	endtask

	// Keyed hash enable cleared by completion and set again by software
	task automatic t_keyed();
		wr(`CONFIG_OFS, 32'h0024_0000);
		check(keyed_en, 1'b1);
		@(posedge clock);
		done <= 1'b1;
		@(posedge clock);
		done <= 1'b0;
		#1;
		check(keyed_en, 1'b0);
		check(cbc_en, 1'b1);
		// Software sets the enable again in the very cycle the engine reports done; the write wins
		@(posedge clock);
		addr <= `CONFIG_OFS;
		wr_data <= 32'h0024_0000;
		wr_stb <= 1'b1;
		done <= 1'b1;
		@(posedge clock);
		wr_stb <= 1'b0;
		done <= 1'b0;
		#1;
		check(keyed_en, 1'b1);
		rd(`CONFIG_OFS, rv);
		check(rv, {REV, 28'h024_0000});
		$display("keyed hash test done");
	endtask

	// Byte count written, then hibernation keeps key and modes
	task automatic t_hib();
		wr(`VALID_BYTES_OFS, 32'hffff_ffff);
		check(valid, 4'hf);
		rd(`VALID_BYTES_OFS, rv);
		check(rv, 32'hf);
		@(posedge clock);
		hib_rst_n <= 1'b0;
		@(posedge clock);
		hib_rst_n <= 1'b1;
		#1;
		check(valid, 4'h0);
		check(key, key_exp);
		check({keyed_en, modes}, 6'h24);
		$display("hibernation test done");
	endtask

	// Unmapped and unaligned places read zero and ignore writes
	task automatic t_unmapped();
		wr(8'h28, 32'hffff_ffff);
		wr(8'h01, 32'hffff_ffff);
		check(key, key_exp);
		rd(8'h28, rv);
		check(rv, 32'h0);
		rd(8'h01, rv);
		check(rv, 32'h0);
		// A mapped read, so that the return to zero afterwards is seen
		rd(`CONFIG_OFS, rv);
		check(rv, {REV, 28'h024_0000});
		@(posedge clock);
		#1;
		check(rd_data, 32'h0);
		$display("unmapped test done");
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial
	begin
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		#1;
		t_reset();
		t_keys();
		t_config();
		t_keyed();
		t_hib();
		t_unmapped();
		conclude();
	end

	initial
	begin
		#20000;
		err_count++;
		conclude();
	end
endmodule
